// ### verilog/seq_pkg.sv
// shared constants, command encodings and carrier structs for the program sequencer
// assumes one clock domain; decoded commands arrive from the execution datapath
// Overview of operation
// RULE1 - 16-bit program counter addresses instruction fetch
// RULE2 - eight-entry 16-bit return stack, push/pop/call/return
// RULE3 - push shifts down, bottom entry lost
// RULE4 - pop shifts up, bottom entry repeats
// RULE5 - push data word, pop top to data
// RULE6 - counter takes increment or branch target
// RULE7 - untaken conditional branch skips target word
// RULE8 - accumulator loads counter for branch, call
// RULE9 - block move uses counter as source
// RULE10 - repeat count N runs next op N+1
// RULE11 - repeated multicycle ops run one per cycle
// RULE12 - table, multiply, block ops use microcall store
// RULE13 - prefetch, decode, execute overlap three deep
// RULE14 - prefetch counter fills holding or queue register
// RULE15 - queued word moves in after completion
// RULE16 - counter tracks execution, steps per instruction
// RULE17 - call and interrupt push the counter
// RULE18 - internal RAM fetch shortens pipe to two
// RULE19 - discontinuity flushes, two dead cycles or one
// RULE20 - nonzero repeat holds counter and prefetch; a repeated block move still steps the counter once per pass
package seq_pkg;

	localparam int ADDR_W    = 16;
	localparam int WORD_W    = 16;
	localparam int STACK_D   = 8;
	localparam int RPT_W     = 8;

	localparam logic [ADDR_W-1:0] PC_RESET   = 16'h0000;
	localparam logic [ADDR_W-1:0] PFC_RESET  = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [RPT_W-1:0]  RPT_RESET  = 8'h00;
	localparam logic [1:0]        DEAD_EXT   = 2'h2;
	localparam logic [1:0]        DEAD_BLK0  = 2'h1;
	localparam logic [ADDR_W-1:0] STEP_ONE   = 16'h0001;
	localparam logic [ADDR_W-1:0] STEP_TWO   = 16'h0002;

	typedef enum logic [13:0] {
		OP_NORMAL     = 14'h0001,
		OP_BRANCH     = 14'h0002,
		OP_COND_BR    = 14'h0004,
		OP_CALL       = 14'h0008,
		OP_INTR       = 14'h0010,
		OP_BR_ACC     = 14'h0020,
		OP_CALL_ACC   = 14'h0040,
		OP_RETURN     = 14'h0080,
		OP_PUSH_WORD  = 14'h0100,
		OP_POP_WORD   = 14'h0200,
		OP_REPEAT     = 14'h0400,
		OP_BLOCK_MOVE = 14'h0800,
		OP_MCALL_IN   = 14'h1000,
		OP_MCALL_OUT  = 14'h2000
	} seq_op_t;

	typedef struct packed {
		seq_op_t             op;
		logic                cond_true;
		logic                dest_block0;
		logic [ADDR_W-1:0]   target;
		logic [WORD_W-1:0]   data_word;
	} seq_cmd_t;

	typedef struct packed {
		logic                ack;
		logic                internal_ram;
		logic [WORD_W-1:0]   word;
	} fetch_rsp_t;

endpackage : seq_pkg

// ### verilog/return_stack.sv
// eight-level return stack with shift-down push and shift-up pop
// assumes push and pop are never requested in the same cycle
`timescale 1ns/1ps
module return_stack
	import seq_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire logic              push,
	input  wire logic              pop,
	input  wire logic [WORD_W-1:0] push_value,
	output logic      [WORD_W-1:0] top
);

	logic [WORD_W-1:0] level_r [STACK_D];

	assign top = level_r[0];

	genvar g;
	generate
		for (g = 0; g < STACK_D; g++) begin : g_level
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					level_r[g] <= WORD_RESET;
				end else if (push) begin
					level_r[g] <= (g == 0) ? push_value : level_r[(g == 0) ? 0 : g-1]; // RULE3
				end else if (pop && g < STACK_D-1) begin
					level_r[g] <= level_r[(g < STACK_D-1) ? g+1 : g]; // RULE4
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_push_shift: assert property (push |=> level_r[1] == $past(level_r[0]) // RULE3
		&& level_r[0] == $past(push_value)) else $error("push did not shift down");
	a_pop_bottom: assert property (pop && !push |=> level_r[STACK_D-1] == $past(level_r[STACK_D-1]) // RULE4
		&& level_r[0] == $past(level_r[1])) else $error("pop did not shift up");

endmodule : return_stack

// ### verilog/repeat_counter.sv
// 8-bit repeat counter: load N, then count down once per repeated execution
// load takes priority when load and step coincide
`timescale 1ns/1ps
module repeat_counter
	import seq_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             load,
	input  wire logic [RPT_W-1:0] load_value,
	input  wire logic             step,
	output logic      [RPT_W-1:0] count,
	output logic                  active
);

	logic [RPT_W-1:0] count_r;

	assign count  = count_r;
	assign active = (count_r != RPT_RESET);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			count_r <= RPT_RESET;
		end else if (load) begin
			count_r <= load_value; // RULE10
		end else if (step && active) begin
			count_r <= count_r - 8'h01; // RULE10
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_rpt_count_down: assert property (step && active && !load |=> count_r == $past(count_r) - 8'h01) // RULE10
		else $error("repeat count did not decrement");
	a_rpt_floor_zero: assert property (!active && !load |=> !active) // RULE10
		else $error("repeat count left zero by itself");

endmodule : repeat_counter

// ### verilog/program_sequencer_pipeline.sv
// program sequencer: program counter, prefetch queue, return stack, repeat, microcall store
// assumes the program memory answers a fetch in the cycle of the request via fetch_rsp.ack,
// and the datapath raises exec_done with the decoded command for the word in instruction_holding_reg
`timescale 1ns/1ps
module program_sequencer_pipeline
	import seq_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	output logic      [ADDR_W-1:0] program_address_bus,
	output logic                   fetch_req,
	input  wire fetch_rsp_t        fetch_rsp,
	output logic                   instr_valid,
	output logic      [WORD_W-1:0] instruction_holding_reg,
	input  wire logic              exec_done,
	input  wire seq_cmd_t          cmd,
	input  wire logic [WORD_W-1:0] acc_value,
	output logic      [ADDR_W-1:0] program_counter,
	output logic      [ADDR_W-1:0] block_src_addr,
	output logic      [WORD_W-1:0] pop_data_word,
	output logic                   pop_data_valid,
	output logic      [RPT_W-1:0]  repeat_count,
	output logic      [ADDR_W-1:0] microcall_return_store
);

	logic [ADDR_W-1:0] pc_r;
	logic [ADDR_W-1:0] pc_nxt;
	logic [ADDR_W-1:0] pfc_r;
	logic [ADDR_W-1:0] pfc_nxt;
	logic [ADDR_W-1:0] mcs_r;
	logic [WORD_W-1:0] ir_r;
	logic              ir_valid_r;
	logic [WORD_W-1:0] qir_r;
	logic              qir_valid_r;
	logic [1:0]        dead_r;
	logic [WORD_W-1:0] pop_word_r;
	logic              pop_valid_r;

	logic              executed;
	logic              rpt_active;
	logic              consume;
	logic              redirect;
	logic              taken;
	logic              fetch_go;
	logic              ir_free;
	logic              stk_push;
	logic              stk_pop;
	logic [WORD_W-1:0] stk_push_value;
	logic [WORD_W-1:0] stk_top;
	logic [ADDR_W-1:0] redirect_addr;

	assign executed = instr_valid && exec_done;
	// while repeating, the holding register keeps the same word
	assign consume  = executed && !rpt_active; // RULE20

	// any non-incremental change of the program counter
	always_comb begin
		taken         = 1'b0;
		redirect_addr = cmd.target;
		unique case (cmd.op)
			OP_BRANCH, OP_CALL, OP_INTR: taken = 1'b1; // RULE6
			OP_COND_BR:                  taken = cmd.cond_true;
			OP_BR_ACC, OP_CALL_ACC: begin
				taken         = 1'b1;
				redirect_addr = acc_value; // RULE8
			end
			OP_RETURN: begin
				taken         = 1'b1;
				redirect_addr = stk_top;
			end
			default:                     taken = 1'b0;
		endcase
	end

	assign redirect = executed && taken;

	// fetch path: stalls on full queue, dead cycles, flush, and repeat
	assign fetch_req = (dead_r == 2'h0) && !redirect && !qir_valid_r
		&& !(rpt_active && ir_valid_r) // RULE20
		&& !(fetch_rsp.internal_ram && ir_valid_r && !consume); // RULE18
	assign fetch_go            = fetch_req && fetch_rsp.ack;
	assign program_address_bus = pfc_r; // RULE14
	assign ir_free             = !ir_valid_r || consume;

	// prefetch counter and microcall store
	always_comb begin
		pfc_nxt = pfc_r;
		if (fetch_go) begin
			pfc_nxt = pfc_r + STEP_ONE; // RULE14
		end
		if (redirect) begin
			pfc_nxt = redirect_addr; // RULE19
		end else if (executed && cmd.op == OP_MCALL_IN) begin
			pfc_nxt = cmd.target; // RULE12
		end else if (executed && cmd.op == OP_MCALL_OUT) begin
			pfc_nxt = mcs_r; // RULE12
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pfc_r <= PFC_RESET;
		end else begin
			pfc_r <= pfc_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mcs_r <= PFC_RESET;
		end else if (executed && cmd.op == OP_MCALL_IN && !redirect) begin
			mcs_r <= fetch_go ? pfc_r + STEP_ONE : pfc_r; // RULE12
		end
	end

	// holding and queue registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ir_r        <= WORD_RESET;
			ir_valid_r  <= 1'b0;
			qir_r       <= WORD_RESET;
			qir_valid_r <= 1'b0;
		end else if (redirect) begin
			ir_valid_r  <= 1'b0; // RULE19
			qir_valid_r <= 1'b0;
		end else begin
			if (consume && qir_valid_r) begin
				ir_r        <= qir_r; // RULE15
				qir_valid_r <= 1'b0;
			end else if (fetch_go && ir_free) begin
				ir_r       <= fetch_rsp.word; // RULE14
				ir_valid_r <= 1'b1;
			end else if (fetch_go) begin
				qir_r       <= fetch_rsp.word; // RULE14
				qir_valid_r <= 1'b1; // RULE13
			end else if (consume) begin
				ir_valid_r <= 1'b0;
			end
		end
	end

	// dead execution cycles after a discontinuity
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dead_r <= 2'h0;
		end else if (redirect) begin
			dead_r <= cmd.dest_block0 ? DEAD_BLK0 : DEAD_EXT; // RULE19
		end else if (dead_r != 2'h0) begin
			dead_r <= dead_r - 2'h1;
		end
	end

	// program counter follows execution, not fetch
	always_comb begin
		pc_nxt = pc_r;
		if (redirect) begin
			pc_nxt = redirect_addr; // RULE6
		end else if (executed && cmd.op == OP_BLOCK_MOVE) begin
			pc_nxt = pc_r + STEP_ONE; // RULE9
		end else if (consume && cmd.op == OP_COND_BR) begin
			pc_nxt = pc_r + STEP_TWO; // RULE7
		end else if (consume) begin
			pc_nxt = pc_r + STEP_ONE; // RULE16
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pc_r <= PC_RESET;
		end else begin
			pc_r <= pc_nxt; // RULE1
		end
	end

	// return stack traffic
	always_comb begin
		stk_push       = 1'b0;
		stk_pop        = 1'b0;
		stk_push_value = pc_r;
		if (executed) begin
			unique case (cmd.op)
				OP_CALL: begin
					stk_push       = 1'b1; // RULE17
					stk_push_value = pc_r + STEP_TWO;
				end
				OP_CALL_ACC: begin
					stk_push       = 1'b1; // RULE17
					stk_push_value = pc_r + STEP_ONE;
				end
				OP_INTR: begin
					stk_push       = 1'b1; // RULE17
					stk_push_value = pc_r;
				end
				OP_PUSH_WORD: begin
					stk_push       = 1'b1; // RULE5
					stk_push_value = cmd.data_word;
				end
				OP_RETURN, OP_POP_WORD: stk_pop = 1'b1; // RULE2
				default:                stk_pop = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pop_word_r  <= WORD_RESET;
			pop_valid_r <= 1'b0;
		end else begin
			pop_valid_r <= executed && cmd.op == OP_POP_WORD;
			if (executed && cmd.op == OP_POP_WORD) begin
				pop_word_r <= stk_top; // RULE5
			end
		end
	end

	return_stack u_stack (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.push       (stk_push),
		.pop        (stk_pop),
		.push_value (stk_push_value),
		.top        (stk_top)
	);

	// each repeated pass completes in one cycle, the word stays in place
	repeat_counter u_repeat (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.load       (consume && cmd.op == OP_REPEAT),
		.load_value (cmd.data_word[RPT_W-1:0]),
		.step       (executed), // RULE11
		.count      (repeat_count),
		.active     (rpt_active)
	);

	assign instr_valid             = ir_valid_r;
	assign instruction_holding_reg = ir_r;
	assign program_counter         = pc_r;
	assign block_src_addr          = pc_r; // RULE9
	assign pop_data_word           = pop_word_r;
	assign pop_data_valid          = pop_valid_r;
	assign microcall_return_store  = mcs_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_pc_step_one: assert property (consume && !redirect && cmd.op == OP_NORMAL // RULE16
		|=> pc_r == $past(pc_r) + STEP_ONE) else $error("pc did not step by one");
	a_cond_skip: assert property (consume && cmd.op == OP_COND_BR && !cmd.cond_true // RULE7
		|=> pc_r == $past(pc_r) + STEP_TWO) else $error("untaken branch did not skip");
	a_acc_branch: assert property (executed && cmd.op inside {OP_BR_ACC, OP_CALL_ACC} // RULE8
		|=> pc_r == $past(acc_value) && pfc_r == $past(acc_value)) else $error("acc load failed");
	a_call_link: assert property (executed && cmd.op == OP_CALL // RULE17
		|=> stk_top == $past(pc_r) + STEP_TWO) else $error("call did not push return");
	a_ret_target: assert property (executed && cmd.op == OP_RETURN // RULE6
		|=> pc_r == $past(stk_top)) else $error("return did not load top");
	a_flush_dead: assert property (redirect && !cmd.dest_block0 // RULE19
		|=> !instr_valid && !fetch_req ##1 !fetch_req ##1 fetch_req || qir_valid_r || rpt_active)
		else $error("flush timing wrong");
	a_flush_blk0: assert property (redirect && cmd.dest_block0 // RULE19
		|=> !fetch_req ##1 (dead_r == 2'h0)) else $error("block0 flush timing wrong");
	a_repeat_hold: assert property (executed && rpt_active && cmd.op != OP_BLOCK_MOVE && !redirect
		|=> $stable(ir_r) && $stable(pc_r) && $stable(pfc_r)) // RULE20
		else $error("repeat did not hold pipeline");
	a_pfc_step: assert property (fetch_go && !executed // RULE14
		|=> pfc_r == $past(pfc_r) + STEP_ONE) else $error("prefetch counter did not step");
	a_mcall_nostack: assert property (executed && cmd.op inside {OP_MCALL_IN, OP_MCALL_OUT} // RULE12
		|=> $stable(stk_top)) else $error("microcall touched return stack");
	a_queue_refill: assert property (consume && qir_valid_r && !redirect // RULE15
		|=> ir_r == $past(qir_r) && instr_valid) else $error("queued word not moved in");

endmodule : program_sequencer_pipeline

// ### tb/program_memory_model.sv
// program memory model: answers a fetch in the cycle of the request unless slow mode withholds the acknowledge, words fixed by address
// assumes the sequencer holds address and request until the acknowledging edge
`timescale 1ns/1ps
module program_memory_model
	import seq_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] program_address_bus,
	input  wire logic              fetch_req,
	input  wire logic              internal_sel,
	input  wire logic              slow,
	output fetch_rsp_t             fetch_rsp
);
	logic              stall_r;
	logic [WORD_W-1:0] last_r;
	logic [WORD_W-1:0] word;

	assign word = {program_address_bus[7:0], program_address_bus[15:8]} ^ 16'h3c5a;

	// slow mode withholds the acknowledge in every other cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			stall_r <= 1'b0;
		else
			stall_r <= slow & ~stall_r;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			last_r <= WORD_RESET;
		else if (fetch_rsp.ack)
			last_r <= word;
	end

	// a released word line shows the inverse of its last value
	always_comb begin
		fetch_rsp.ack          = rstn & fetch_req & ~stall_r;
		fetch_rsp.internal_ram = internal_sel;
		fetch_rsp.word         = fetch_rsp.ack ? word : ~last_r;
	end
endmodule : program_memory_model

// ### tb/program_sequencer_pipeline_bench.sv
// self-checking bench for the program sequencer, random commands from a fixed lfsr
// assumes the memory model words are a fixed function of their address
`timescale 1ns/1ps
module program_sequencer_pipeline_bench
	import seq_pkg::*;
;
	logic              clk_sys;
	logic              rstn;
	logic [ADDR_W-1:0] program_address_bus;
	logic              fetch_req;
	fetch_rsp_t        fetch_rsp;
	logic              instr_valid;
	logic [WORD_W-1:0] instruction_holding_reg;
	logic              exec_done;
	seq_cmd_t          cmd;
	logic [WORD_W-1:0] acc_value;
	logic [ADDR_W-1:0] program_counter;
	logic [ADDR_W-1:0] block_src_addr;
	logic [WORD_W-1:0] pop_data_word;
	logic              pop_data_valid;
	logic [RPT_W-1:0]  repeat_count;
	logic [ADDR_W-1:0] microcall_return_store;
	logic              internal_sel;
	logic              slow;
	int                n_errors;
	int                n_compared;
	int                i;
	logic [15:0]       seed;
	logic [ADDR_W-1:0] pc_exp;
	logic [RPT_W-1:0]  rc_exp;
	logic [WORD_W-1:0] st_exp [STACK_D];
	logic              sync;
	logic [ADDR_W-1:0] mcs_save;
	seq_op_t           tbl [11] = '{OP_NORMAL, OP_BRANCH, OP_COND_BR, OP_CALL, OP_INTR, OP_BR_ACC,
		OP_CALL_ACC, OP_RETURN, OP_PUSH_WORD, OP_POP_WORD, OP_BLOCK_MOVE};

	program_sequencer_pipeline dut (.clk_sys(clk_sys), .rstn(rstn),
		.program_address_bus(program_address_bus), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp),
		.instr_valid(instr_valid), .instruction_holding_reg(instruction_holding_reg),
		.exec_done(exec_done), .cmd(cmd), .acc_value(acc_value),
		.program_counter(program_counter), .block_src_addr(block_src_addr),
		.pop_data_word(pop_data_word), .pop_data_valid(pop_data_valid),
		.repeat_count(repeat_count), .microcall_return_store(microcall_return_store));

	program_memory_model mem (.clk_sys(clk_sys), .rstn(rstn),
		.program_address_bus(program_address_bus), .fetch_req(fetch_req),
		.internal_sel(internal_sel), .slow(slow), .fetch_rsp(fetch_rsp));

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	function automatic logic [ADDR_W-1:0] mem_word(input logic [ADDR_W-1:0] a);
		return {a[7:0], a[15:8]} ^ 16'h3c5a;
	endfunction : mem_word

	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		n_compared++;
		if (seen !== want) begin
			n_errors++;
			$display("MISMATCH %0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask : check

	task automatic finish_test;
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	// reference model of one execution: counter, stack and repeat count
	task automatic model_step(input seq_cmd_t c, output logic [WORD_W-1:0] popped);
		logic              hold;
		logic [WORD_W-1:0] v;
		hold = (rc_exp != 8'h00);
		popped = st_exp[0];
		if (hold)
			rc_exp = rc_exp - 8'h01;
		v = (c.op == OP_CALL) ? pc_exp + STEP_TWO : (c.op == OP_CALL_ACC) ? pc_exp + STEP_ONE :
			(c.op == OP_INTR) ? pc_exp : c.data_word;
		if (c.op inside {OP_CALL, OP_CALL_ACC, OP_INTR, OP_PUSH_WORD}) begin
			for (int j = STACK_D - 1; j > 0; j--)
				st_exp[j] = st_exp[j-1];
			st_exp[0] = v;
		end
		if (c.op inside {OP_RETURN, OP_POP_WORD}) begin
			for (int j = 0; j < STACK_D - 1; j++)
				st_exp[j] = st_exp[j+1];
		end
		case (c.op)
			OP_BRANCH, OP_CALL, OP_INTR, OP_BR_ACC, OP_CALL_ACC: pc_exp = c.target;
			OP_COND_BR: pc_exp = c.cond_true ? c.target : pc_exp + STEP_TWO;
			OP_RETURN: pc_exp = popped;
			OP_REPEAT: begin
				rc_exp = c.data_word[7:0];
				pc_exp = pc_exp + STEP_ONE;
			end
			OP_BLOCK_MOVE: pc_exp = pc_exp + STEP_ONE;
			default: pc_exp = hold ? pc_exp : pc_exp + STEP_ONE;
		endcase
	endtask : model_step

	task automatic run_op(input seq_cmd_t c, input int k);
		logic [WORD_W-1:0] popped;
		int                n;
		logic              flush;
		n = 0;
		while (instr_valid !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		check(n, n % 200, "valid wait");
		if (sync)
			check(instruction_holding_reg, mem_word(pc_exp), "holding word");
		flush = c.op inside {OP_BRANCH, OP_CALL, OP_INTR, OP_BR_ACC, OP_CALL_ACC, OP_RETURN} ||
			(c.op == OP_COND_BR && c.cond_true);
		@(posedge clk_sys);
		exec_done <= 1'b1;
		cmd <= c;
		acc_value <= c.target;
		internal_sel <= seed[2];
		slow <= seed[3];
		repeat (k) begin
			@(posedge clk_sys);
			model_step(c, popped);
		end
		exec_done <= 1'b0;
		@(negedge clk_sys);
		check(program_counter, pc_exp, "pc");
		check(block_src_addr, pc_exp, "block source");
		check(repeat_count, rc_exp, "repeat count");
		check(pop_data_valid, c.op == OP_POP_WORD, "pop valid");
		if (c.op == OP_POP_WORD)
			check(pop_data_word, popped, "pop word");
		if (c.op == OP_MCALL_IN) begin
			check(program_address_bus, c.target, "microcall entry");
			mcs_save = microcall_return_store;
		end
		if (c.op == OP_MCALL_OUT)
			check(program_address_bus, mcs_save, "microcall return");
		if (flush) begin
			n = 0;
			while (fetch_req !== 1'b1 && n < 8) begin
				n++;
				@(negedge clk_sys);
			end
			check(n, c.dest_block0 ? DEAD_BLK0 : DEAD_EXT, "dead cycles");
			check(program_address_bus, pc_exp, "refetch address");
			sync = 1'b1;
		end else if (c.op != OP_NORMAL)
			sync = 1'b0;
	endtask : run_op

	task automatic do_op(input seq_op_t op, input logic [15:0] v, input int k);
		seq_cmd_t c;
		seed = lfsr_next(seed);
		c = '0;
		c.op = op;
		c.target = v;
		c.data_word = v;
		c.cond_true = seed[0];
		c.dest_block0 = seed[1];
		run_op(c, k);
	endtask : do_op

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial begin
		#(5 * 40000);
		n_errors++;
		finish_test;
	end

	initial begin
		rstn = 1'b0;
		exec_done = 1'b0;
		cmd = '0;
		acc_value = 16'h0000;
		internal_sel = 1'b0;
		slow = 1'b0;
		n_errors = 0;
		n_compared = 0;
		seed = 16'h1127;
		pc_exp = PC_RESET;
		rc_exp = RPT_RESET;
		sync = 1'b1;
		mcs_save = PFC_RESET;
		foreach (st_exp[j])
			st_exp[j] = WORD_RESET;
		repeat (6) @(posedge clk_sys);
		check(program_counter, PC_RESET, "reset pc");
		check(instr_valid, 1'b0, "reset valid");
		rstn <= 1'b1;
		@(negedge clk_sys);
		for (i = 0; i < 9; i++)
			do_op(OP_PUSH_WORD, 16'h1000 + 16'(i), 1);
		for (i = 0; i < 10; i++)
			do_op(OP_POP_WORD, 16'h0000, 1);
		do_op(OP_PUSH_WORD, 16'hbeef, 1);
		do_op(OP_MCALL_IN, 16'h0200, 1);
		do_op(OP_MCALL_OUT, 16'h0000, 1);
		do_op(OP_POP_WORD, 16'h0000, 1);
		do_op(OP_BRANCH, 16'h0040, 1);
		repeat (6) @(negedge clk_sys);
		do_op(OP_NORMAL, 16'h0000, 1);
		do_op(OP_NORMAL, 16'h0000, 1);
		do_op(OP_REPEAT, 16'h0000, 1);
		do_op(OP_NORMAL, 16'h0000, 1);
		do_op(OP_REPEAT, {13'h0000, seed[2:0]}, 1);
		do_op(OP_NORMAL, 16'h0000, int'(rc_exp) + 1);
		do_op(OP_REPEAT, 16'h0003, 1);
		do_op(OP_BLOCK_MOVE, 16'h0000, 4);
		for (i = 0; i < 80; i++)
			do_op(tbl[seed % 11], lfsr_next(seed), 1);
		finish_test;
	end
endmodule : program_sequencer_pipeline_bench
